// File: ipmu_cfg.svh
// Constants of the interrupt priority and masking unit: offsets, fields, resets.
// Assumes a 10 MHz system clock and 32-bit APB access with word-aligned offsets.
// Behaviour
// - Vector slot sits at vector times four (advanced) or times two (normal).
// - Serial port 0 sources use vectors 52..55, sharing one priority bit.
// - Serial port 1 sources use vectors 56..59, sharing another priority bit.
// - Vector address forms the low 16 bits of the fetch address.
// - User mask enable 1 gates with global flag only; 0 with both.
// - Nonmaskable request always accepted except in reset or standby.
// - A source whose enable bit is 0 makes no request.
// - Request forwarded only when condition present and enable bit is 1.
// - Highest level wins; ties by vector order; others stay pending.
// - Enable 1: global flag 1 blocks maskables, 0 allows; level 1 first.
// - Masked requests stay pending while present and are served later.
// - Enable 0: level 0 masked whenever global flag is 1.
// - Enable 0: level 1 masked only when both flags are 1.
// - Enable 0, global flag 0: selected request accepted at any level.
// - Enable 0, global 1, user 0: only level 1 and nonmaskable accepted.
// - Register A 20h, B 00h lifts external pair 2 and 3 above others.
// - Exception sequence starts only after the current instruction ends.
// - Sequence stacks program counter and condition register; PC is resume address.
// - Enable 1: sequence sets global mask flag after stacking.
// - Enable 0: sequence sets both mask flags after stacking.
// - Vector address formed; handler address loaded and executed from.
// - Default order: smaller vector wins; only maskables reorderable.
// - Nonmaskable uses vector 7 and ranks above all.
`ifndef IPMU_CFG_SVH
`define IPMU_CFG_SVH

`define IPMU_OFS_SYSCTL 12'h000
`define IPMU_OFS_PRIA 12'h004
`define IPMU_OFS_PRIB 12'h008
`define IPMU_OFS_CCR 12'h00C
`define IPMU_OFS_EN_LO 12'h010
`define IPMU_OFS_EN_HI 12'h014
`define IPMU_OFS_STATUS 12'h018

`define IPMU_SYSCTL_UE_BIT 3
`define IPMU_SYSCTL_ADV_BIT 1
`define IPMU_SYSCTL_RST 8'h0A
`define IPMU_CCR_I_BIT 7
`define IPMU_CCR_UI_BIT 6
`define IPMU_PRI_RST 8'h00

`define IPMU_VEC_NMI 6'h07
`define IPMU_VEC_FIRST 12
`define IPMU_VEC_LAST 59
`define IPMU_NSRC 48
// Bit v set where vector v has a maskable source; vector 7 is nmi, all others reserved
`define IPMU_VEC_VALID 64'h0FF0_0FF7_7793_F000
`define IPMU_SP_STEP 24'h000004

`endif

// File: ipmu_pkg.sv
// Types of the interrupt priority and masking unit.
// Assumes ipmu_cfg.svh is compiled alongside.
package ipmu_pkg;
    typedef enum logic [2:0] {
        IPMU_IDLE = 3'b000,
        IPMU_OFFER = 3'b001,
        IPMU_PUSH = 3'b010,
        IPMU_MASK = 3'b011,
        IPMU_FETCH = 3'b100,
        IPMU_JUMP = 3'b101
    } ipmu_state_t;
    typedef logic [5:0] ipmu_vec_t;
    typedef logic [23:0] ipmu_addr_t;
endpackage : ipmu_pkg

// File: ipmu_top.sv
// Interrupt priority selection, masking and exception entry sequencer.
// Assumes source conditions and the nmi pulse come from logic on sys_clk_i.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "ipmu_cfg.svh"

module ipmu_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Interrupt sources, index is vector minus 12
    input wire logic [`IPMU_NSRC-1:0] src_cond_i,
    input wire logic nmi_i,
    input wire logic stby_i,
    // Core side
    input wire logic instr_end_i,
    input wire ipmu_pkg::ipmu_addr_t ret_pc_i,
    input wire ipmu_pkg::ipmu_addr_t sp_i,
    output logic irq_req_o,
    output ipmu_pkg::ipmu_vec_t irq_vec_o,
    output logic mask_i_o,
    output logic mask_ui_o,
    output logic pc_load_o,
    output ipmu_pkg::ipmu_addr_t pc_value_o,
    // Memory port for stacking and vector fetch
    output logic mem_req_o,
    output logic mem_we_o,
    output ipmu_pkg::ipmu_addr_t mem_addr_o,
    output logic [31:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i
);
    import ipmu_pkg::*;

    ipmu_state_t state;
    logic [7:0] sysctl;
    logic [7:0] pri_a;
    logic [7:0] pri_b;
    logic [31:0] en_lo;
    logic [15:0] en_hi;
    logic nmi_pend;
    logic [63:0] en_vec;
    logic [63:0] pend;
    logic hit_lvl1;
    logic hit_lvl0;
    ipmu_vec_t vec_lvl1;
    ipmu_vec_t vec_lvl0;
    ipmu_vec_t next_vec;
    logic next_ok;
    logic allow_lvl0;
    logic allow_lvl1;
    logic ue;
    logic adv;
    logic apb_wr;
    logic apb_rd;
    logic addr_hit;
    logic [15:0] vec_addr;
    // Literal held as a constant so that single bits can be selected
    localparam logic [63:0] VEC_VALID = `IPMU_VEC_VALID;

    assign ue = sysctl[`IPMU_SYSCTL_UE_BIT];
    assign adv = sysctl[`IPMU_SYSCTL_ADV_BIT];
    assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
    assign apb_rd = psel_i & penable_i & ~pready_o & ~pwrite_i;

    // Priority bit that governs vector v; unlisted vectors stay at level 0
    function automatic logic level_of(input int v, input logic [7:0] a, input logic [7:0] b);
        logic r;
        r = 1'b0;
        if (v == 12) begin
            r = a[7];
        end else if (v == 13) begin
            r = a[6];
        end else if (v >= 14 && v <= 15) begin
            r = a[5];
        end else if (v >= 16 && v <= 17) begin
            r = a[4];
        end else if (v >= 20 && v <= 23) begin
            r = a[3];
        end else if (v >= 24 && v <= 27) begin
            r = a[2];
        end else if (v >= 28 && v <= 31) begin
            r = a[1];
        end else if (v >= 32 && v <= 35) begin
            r = a[0];
        end else if (v >= 36 && v <= 39) begin
            r = b[7];
        end else if (v >= 40 && v <= 43) begin
            r = b[6];
        end else if (v >= 52 && v <= 55) begin
            r = b[3];
        end else if (v >= 56 && v <= 59) begin
            r = b[2];
        end
        return r;
    endfunction

    // Per-vector request: condition, enable and a real source behind it
    genvar gv;
    generate
        for (gv = 0; gv < 64; gv++) begin : g_pend
            if (gv >= `IPMU_VEC_FIRST && gv <= `IPMU_VEC_LAST) begin : g_src
                if (gv < 44) begin : g_lo
                    assign en_vec[gv] = en_lo[gv-12];
                end else begin : g_hi
                    assign en_vec[gv] = en_hi[gv-44];
                end
                assign pend[gv] = src_cond_i[gv-12] & en_vec[gv] & VEC_VALID[gv];
            end else begin : g_none
                assign en_vec[gv] = 1'b0;
                assign pend[gv] = 1'b0;
            end
        end
    endgenerate

    // Walk downward so the smallest pending vector is kept per level
    always_comb begin
        hit_lvl1 = 1'b0;
        hit_lvl0 = 1'b0;
        vec_lvl1 = 6'h00;
        vec_lvl0 = 6'h00;
        for (int v = `IPMU_VEC_LAST; v >= `IPMU_VEC_FIRST; v--) begin
            if (pend[v] && level_of(v, pri_a, pri_b)) begin
                hit_lvl1 = 1'b1;
                vec_lvl1 = 6'(v);
            end else if (pend[v]) begin
                hit_lvl0 = 1'b1;
                vec_lvl0 = 6'(v);
            end
        end
    end

    // Level 1 never loses to level 0; masked levels simply wait
    assign allow_lvl0 = ~mask_i_o;
    assign allow_lvl1 = ue ? ~mask_i_o : ~(mask_i_o & mask_ui_o);

    always_comb begin
        next_ok = 1'b0;
        next_vec = 6'h00;
        if (nmi_pend) begin
            next_ok = 1'b1;
            next_vec = `IPMU_VEC_NMI;
        end else if (hit_lvl1) begin
            next_ok = allow_lvl1;
            next_vec = vec_lvl1;
        end else if (hit_lvl0) begin
            next_ok = allow_lvl0;
            next_vec = vec_lvl0;
        end
    end

    assign vec_addr = adv ? {8'h00, irq_vec_o, 2'b00} : {9'h000, irq_vec_o, 1'b0};

    // Nmi pending latch; a new pulse wins over the clear on acceptance
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nmi_pend <= 1'b0;
        end else if (stby_i) begin
            nmi_pend <= 1'b0;
        end else if (nmi_i) begin
            nmi_pend <= 1'b1;
        end else if (state == IPMU_OFFER && instr_end_i && irq_vec_o == `IPMU_VEC_NMI) begin
            nmi_pend <= 1'b0;
        end
    end

    // Exception entry sequencer
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= IPMU_IDLE;
            irq_req_o <= 1'b0;
            irq_vec_o <= 6'h00;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 24'h000000;
            mem_wdata_o <= 32'h00000000;
            pc_load_o <= 1'b0;
            pc_value_o <= 24'h000000;
        end else if (stby_i) begin
            state <= IPMU_IDLE;
            irq_req_o <= 1'b0;
            mem_req_o <= 1'b0;
            pc_load_o <= 1'b0;
        end else begin
            unique case (state)
                IPMU_IDLE: begin
                    pc_load_o <= 1'b0;
                    if (next_ok) begin
                        irq_req_o <= 1'b1;
                        irq_vec_o <= next_vec;
                        state <= IPMU_OFFER;
                    end
                end
                IPMU_OFFER: begin
                    // Held until the instruction boundary, even if a better source turns up
                    if (instr_end_i) begin
                        irq_req_o <= 1'b0;
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b1;
                        mem_addr_o <= sp_i - `IPMU_SP_STEP;
                        mem_wdata_o <= {6'h00, mask_i_o, mask_ui_o, ret_pc_i};
                        state <= IPMU_PUSH;
                    end
                end
                IPMU_PUSH: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        state <= IPMU_MASK;
                    end
                end
                IPMU_MASK: begin
                    mem_req_o <= 1'b1;
                    mem_addr_o <= {8'h00, vec_addr};
                    state <= IPMU_FETCH;
                end
                IPMU_FETCH: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        pc_load_o <= 1'b1;
                        pc_value_o <= adv ? mem_rdata_i[23:0] : {8'h00, mem_rdata_i[15:0]};
                        state <= IPMU_JUMP;
                    end
                end
                IPMU_JUMP: begin
                    pc_load_o <= 1'b0;
                    state <= IPMU_IDLE;
                end
                default: begin
                    state <= IPMU_IDLE;
                end
            endcase
        end
    end

    // Mask flags; the sequence setting them wins over a software write
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_i_o <= 1'b1;
            mask_ui_o <= 1'b0;
        end else if (state == IPMU_MASK) begin
            mask_i_o <= 1'b1;
            if (!ue) begin
                mask_ui_o <= 1'b1;
            end
        end else if (apb_wr && paddr_i == `IPMU_OFS_CCR) begin
            mask_i_o <= pwdata_i[`IPMU_CCR_I_BIT];
            mask_ui_o <= pwdata_i[`IPMU_CCR_UI_BIT];
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sysctl <= `IPMU_SYSCTL_RST;
            pri_a <= `IPMU_PRI_RST;
            pri_b <= `IPMU_PRI_RST;
            en_lo <= 32'h00000000;
            en_hi <= 16'h0000;
        end else if (apb_wr) begin
            unique case (paddr_i)
                `IPMU_OFS_SYSCTL: sysctl <= pwdata_i[7:0];
                `IPMU_OFS_PRIA: pri_a <= pwdata_i[7:0];
                `IPMU_OFS_PRIB: pri_b <= pwdata_i[7:0];
                `IPMU_OFS_EN_LO: en_lo <= pwdata_i;
                `IPMU_OFS_EN_HI: en_hi <= pwdata_i[15:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        unique case (paddr_i)
            `IPMU_OFS_SYSCTL,
            `IPMU_OFS_PRIA,
            `IPMU_OFS_PRIB,
            `IPMU_OFS_CCR,
            `IPMU_OFS_EN_LO,
            `IPMU_OFS_EN_HI,
            `IPMU_OFS_STATUS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // One wait state so every bus output leaves a flip-flop
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~addr_hit;
            prdata_o <= 32'h00000000;
            if (apb_rd) begin
                unique case (paddr_i)
                    `IPMU_OFS_SYSCTL: prdata_o <= {24'h000000, sysctl};
                    `IPMU_OFS_PRIA: prdata_o <= {24'h000000, pri_a};
                    `IPMU_OFS_PRIB: prdata_o <= {24'h000000, pri_b};
                    `IPMU_OFS_CCR: prdata_o <= {24'h000000, mask_i_o, mask_ui_o, 6'h00};
                    `IPMU_OFS_EN_LO: prdata_o <= en_lo;
                    `IPMU_OFS_EN_HI: prdata_o <= {16'h0000, en_hi};
                    `IPMU_OFS_STATUS: prdata_o <= {16'h0000, 5'h00, state, nmi_pend,
                        next_ok, next_vec};
                    default: prdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    property p_req_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (irq_req_o && !instr_end_i && !stby_i) |=> (irq_req_o && $stable(irq_vec_o));
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");

    property p_no_reserved;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        irq_req_o |-> (irq_vec_o == `IPMU_VEC_NMI || VEC_VALID[irq_vec_o]);
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved vector offered");

    property p_nmi_taken;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == IPMU_IDLE && nmi_pend && !stby_i) |=> (irq_req_o && irq_vec_o == 6'h07);
    endproperty
    a_nmi_taken: assert property (p_nmi_taken) else $error("nmi not offered");

    property p_lvl0_masked;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == IPMU_IDLE && !nmi_pend && mask_i_o && !hit_lvl1) |=> !irq_req_o;
    endproperty
    a_lvl0_masked: assert property (p_lvl0_masked) else $error("level 0 passed mask");

    property p_lvl1_masked;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == IPMU_IDLE && !nmi_pend && mask_i_o && (ue || mask_ui_o)) |=> !irq_req_o;
    endproperty
    a_lvl1_masked: assert property (p_lvl1_masked) else $error("masked request offered");

    property p_lvl1_pass;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == IPMU_IDLE && !stby_i && !nmi_pend && hit_lvl1 && !ue && !mask_ui_o)
            |=> (irq_req_o && irq_vec_o == $past(vec_lvl1));
    endproperty
    a_lvl1_pass: assert property (p_lvl1_pass) else $error("level 1 held wrongly");

    property p_wait_boundary;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == IPMU_OFFER && !instr_end_i) |=> !mem_req_o;
    endproperty
    a_wait_boundary: assert property (p_wait_boundary) else $error("sequence before boundary");

    property p_stack;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == IPMU_OFFER && instr_end_i && !stby_i)
            |=> (mem_req_o && mem_we_o && mem_wdata_o[23:0] == $past(ret_pc_i)
                && mem_addr_o == $past(sp_i) - 24'h000004);
    endproperty
    a_stack: assert property (p_stack) else $error("bad stack write");

    property p_flags_set;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == IPMU_MASK && !stby_i) |=> (mask_i_o && (ue || mask_ui_o));
    endproperty
    a_flags_set: assert property (p_flags_set) else $error("mask flags not set");

    property p_vec_addr;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == IPMU_MASK && !stby_i) |=> (mem_addr_o[23:16] == 8'h00
            && mem_addr_o[15:0] == (adv ? 16'(irq_vec_o) * 16'h0004 : 16'(irq_vec_o) * 16'h0002));
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("bad vector address");

    property p_jump;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == IPMU_FETCH && mem_ack_i && !stby_i) |=> (pc_load_o ##1 !pc_load_o);
    endproperty
    a_jump: assert property (p_jump) else $error("handler not loaded once");

endmodule // ipmu_top
`default_nettype wire

// File: ipmu_core_model.sv
// Behavioural core and memory facing the interrupt unit's core side.
// Assumes the unit's registered request, memory port and pulse timing.
`timescale 1ns/100ps
`default_nettype none

module ipmu_core_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Unit outputs, plus the bench's slow select
    input wire logic irq_req_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire ipmu_pkg::ipmu_addr_t mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    input wire logic slow_i,
    // Unit inputs
    output logic instr_end_o,
    output ipmu_pkg::ipmu_addr_t ret_pc_o,
    output ipmu_pkg::ipmu_addr_t sp_o,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o,
    // Captured traffic for the bench
    output ipmu_pkg::ipmu_addr_t stk_addr_o,
    output logic [31:0] stk_data_o,
    output ipmu_pkg::ipmu_addr_t vec_addr_o
);
    import ipmu_pkg::*;
    logic [2:0] dly;
    logic [1:0] gap;
    logic busy;

    // Gap stops a second ack while the request is still being dropped
    assign busy = (irq_req_i && !instr_end_o) || (mem_req_i && gap == 2'h0 && !mem_ack_o);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dly <= 3'h0;
            gap <= 2'h0;
            instr_end_o <= 1'b0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 32'h0000_0000;
            ret_pc_o <= 24'h001000;
            sp_o <= 24'h00FF00;
            stk_addr_o <= 24'h000000;
            stk_data_o <= 32'h0000_0000;
            vec_addr_o <= 24'h000000;
        end else begin
            instr_end_o <= 1'b0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (gap != 2'h0) gap <= gap - 2'h1;
            dly <= busy ? dly + 3'h1 : 3'h0;
            if (busy && dly >= (slow_i ? 3'h4 : 3'h1)) begin
                dly <= 3'h0;
                if (irq_req_i) begin
                    instr_end_o <= 1'b1;
                    ret_pc_o <= ret_pc_o + 24'h000136;
                    sp_o <= sp_o - 24'h000010;
                end else begin
                    mem_ack_o <= 1'b1;
                    gap <= 2'h2;
                    if (mem_we_i) begin
                        stk_addr_o <= mem_addr_i;
                        stk_data_o <= mem_wdata_i;
                    end else begin
                        vec_addr_o <= mem_addr_i;
                        mem_rdata_o <= {16'hFF12, 8'h00, mem_addr_i[7:0]};
                    end
                end
            end
        end
    end
endmodule // ipmu_core_model

`default_nettype wire

// File: interrupt_priority_masking_unit_tb.sv
// Self-checking bench: APB setup, random sources, masking and entry sequence.
// Assumes ipmu_top and ipmu_core_model; clock 10 MHz.
`timescale 1ns/100ps
`default_nettype none

module interrupt_priority_masking_unit_tb;
    import ipmu_pkg::*;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, mem_wdata_o, mem_rdata_i, stk_data;
    logic pready_o, pslverr_o, irq_req_o, mask_i_o, mask_ui_o, pc_load_o, mem_req_o, mem_we_o;
    logic [47:0] src_cond_i = 48'h0;
    logic nmi_i = 1'b0, stby_i = 1'b0, slow = 1'b0, instr_end_i, mem_ack_i;
    ipmu_addr_t ret_pc_i, sp_i, pc_value_o, mem_addr_o, stk_addr, vec_addr;
    ipmu_vec_t irq_vec_o;
    int num_errors = 0, comparisons = 0, cyc = 0;

    ipmu_top u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .src_cond_i(src_cond_i), .nmi_i(nmi_i), .stby_i(stby_i), .instr_end_i(instr_end_i),
        .ret_pc_i(ret_pc_i), .sp_i(sp_i), .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o),
        .mask_i_o(mask_i_o), .mask_ui_o(mask_ui_o), .pc_load_o(pc_load_o),
        .pc_value_o(pc_value_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i));
    ipmu_core_model u_core (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .irq_req_i(irq_req_o),
        .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .slow_i(slow), .instr_end_o(instr_end_i),
        .ret_pc_o(ret_pc_i), .sp_o(sp_i), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i),
        .stk_addr_o(stk_addr), .stk_data_o(stk_data), .vec_addr_o(vec_addr));

    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic print_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        r = prdata_o;
        e = pslverr_o;
        chk(pready_o, 1, "apb answer");
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x, "read data");
        chk(e, xe, "slave error");
    endtask

    function automatic bit valid(int v);
        return v inside {[12:17], 20, [23:26], [28:30], [32:34], [36:43], [52:59]};
    endfunction

    function automatic bit lvl(int v, logic [7:0] pa, logic [7:0] pb);
        if (v == 12) return pa[7];
        if (v == 13) return pa[6];
        if (v < 16) return pa[5];
        if (v < 20) return pa[4];
        if (v < 36) return pa[3 - (v - 20) / 4];
        if (v < 44) return pb[7 - (v - 36) / 4];
        return pb[3 - (v - 52) / 4];
    endfunction

    function automatic int expv(logic [47:0] en, logic [47:0] pend, logic [7:0] pa,
                                logic [7:0] pb, logic ue, logic i, logic ui);
        int b;
        b = -1;
        for (int v = 12; v < 60; v++)
            if (valid(v) && pend[v - 12] && en[v - 12] && (b < 0 || lvl(v, pa, pb) > lvl(b, pa, pb)))
                b = v;
        if (b < 0) return -1;
        return (!i || (!ue && !ui && lvl(b, pa, pb))) ? b : -1;
    endfunction

    task automatic quiet();
        repeat (6) begin
            @(posedge sys_clk_i);
            chk(irq_req_o, 0, "masked request offered");
        end
    endtask

    task automatic run_irq(input int v, input logic ue, input logic i, input logic ui,
                           input logic adv);
        int n;
        ipmu_addr_t va;
        n = 0;
        while (irq_req_o !== 1'b1 && n < 40) begin
            @(posedge sys_clk_i);
            n++;
        end
        chk(irq_req_o, 1, "request offered");
        chk(irq_vec_o, v, "offered vector");
        while (pc_load_o !== 1'b1 && n < 200) begin
            @(posedge sys_clk_i);
            n++;
        end
        chk(pc_load_o, 1, "handler load");
        va = adv ? 24'(v * 4) : 24'(v * 2);
        chk(stk_addr, sp_i - 24'h000004, "stack address");
        chk(stk_data, {6'h00, i, ui, ret_pc_i}, "stacked word");
        chk(vec_addr, va, "vector address");
        chk(pc_value_o, adv ? {16'h1200, va[7:0]} : {16'h0000, va[7:0]}, "handler");
        chk(mask_i_o, 1, "global mask after entry");
        chk(mask_ui_o, ue ? ui : 1'b1, "user mask after entry");
    endtask

    task automatic scen(input logic ue, input logic adv, input logic [7:0] pa,
                        input logic [7:0] pb, input logic [47:0] en, input logic [47:0] pend,
                        input logic i, input logic ui);
        int e;
        wr(12'h00C, 32'h0000_00C0);
        src_cond_i <= pend;
        slow <= 1'($urandom);
        wr(12'h000, {28'h0, ue, 1'b0, adv, 1'b0});
        wr(12'h004, {24'h0, pa});
        wr(12'h008, {24'h0, pb});
        wr(12'h010, en[31:0]);
        wr(12'h014, {16'h0, en[47:32]});
        wr(12'h00C, {24'h0, i, ui, 6'h00});
        e = expv(en, pend, pa, pb, ue, i, ui);
        if (e < 0) begin
            quiet();
            wr(12'h00C, 32'h0);
            i = 1'b0;
            ui = 1'b0;
            e = expv(en, pend, pa, pb, ue, i, ui);
        end
        if (e < 0) quiet();
        else run_irq(e, ue, i, ui, adv);
        @(posedge sys_clk_i);
        src_cond_i <= 48'h0;
    endtask

    initial begin
        void'($urandom(32'h332d));
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        chk(mask_i_o, 1, "global mask at reset");
        rd_chk(12'h000, 32'h0000_000A, 1'b0);
        rd_chk(12'h004, 32'h0, 1'b0);
        rd_chk(12'h008, 32'h0, 1'b0);
        rd_chk(12'h00C, 32'h0000_0080, 1'b0);
        rd_chk(12'h01C, 32'h0, 1'b1);
        $display("test reset and registers done");
        // Pair 14/15 lifted above 12 and 28
        scen(0, 1, 8'h20, 8'h00, '1, 48'h0000_0001_0005, 1, 0);
        scen(0, 1, 8'h20, 8'h00, '1, 48'h0000_0001_0005, 1, 1);
        scen(1, 0, 8'h00, 8'h00, '1, 48'h0200_0000_0000, 0, 0);
        scen(1, 1, 8'h00, 8'h04, '1, 48'hF000_0000_0000, 1, 0);
        scen(1, 1, 8'h00, 8'h00, '1, 48'h0000_0000_00C0, 0, 0);
        scen(0, 1, 8'h00, 8'h00, 48'h0, 48'h0010_0000_0000, 0, 0);
        $display("test corner cases done");
        repeat (30)
            scen(1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom),
                 {16'($urandom), 32'($urandom)}, {16'($urandom), 32'($urandom)},
                 1'($urandom), 1'($urandom));
        $display("test random selection done");
        wr(12'h000, 32'h0000_000A);
        wr(12'h00C, 32'h0000_00C0);
        @(posedge sys_clk_i);
        nmi_i <= 1'b1;
        @(posedge sys_clk_i);
        nmi_i <= 1'b0;
        run_irq(7, 1, 1, 1, 1);
        @(posedge sys_clk_i);
        stby_i <= 1'b1;
        nmi_i <= 1'b1;
        @(posedge sys_clk_i);
        nmi_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        stby_i <= 1'b0;
        quiet();
        $display("test nonmaskable and standby done");
        print_verdict();
    end
endmodule // interrupt_priority_masking_unit_tb

`default_nettype wire
